// ---- logic/lugc_regs.svh ----
/*
  Constants for the line unit global control register: field positions, reset value and timing.
  Assumes inclusion by the design modules of this block only; the package does not include it.
*/
`ifndef LUGC_REGS_SVH
`define LUGC_REGS_SVH
`define LUGC_GCR0_RESET 8'h00
`define LUGC_BIT_RAIL 7
`define LUGC_BIT_ATAO 6
`define LUGC_BIT_RXEDGE 5
`define LUGC_BIT_TXEDGE 4
`define LUGC_BIT_POL 3
`define LUGC_BIT_UNUSED 2
`define LUGC_BIT_GIE 1
`define LUGC_BIT_SRST 0
`define LUGC_GCR0_WMASK 8'hFB
`define LUGC_CLK_MHZ 100
`define LUGC_SRST_MIN_NS 10000
`define LUGC_SRST_CYCLES ((`LUGC_SRST_MIN_NS * `LUGC_CLK_MHZ + 999) / 1000)
`define LUGC_LOS_SHORT 175
`define LUGC_LOS_LONG 4096
`define LUGC_CNT_W 13
`endif

// ---- logic/lugc_pkg.sv ----
/*
  Types shared by the line unit global control modules.
  Assumes the register constants header is on the include path.
*/
package lugc_pkg;
  typedef struct packed {
    logic pos;
    logic neg;
  } lugc_rail_s;
  typedef enum logic [2:0] {
    LUGC_ST_IDLE = 3'b001,
    LUGC_ST_HOLD = 3'b010,
    LUGC_ST_RESET = 3'b100
  } lugc_srst_e;
endpackage

// ---- logic/lugc_los_detect.sv ----
/*
  Receive loss-of-signal detector: counts consecutive zero line bits.
  Assumes one bit strobe per received line bit, in the system clock domain.
*/
`include "lugc_regs.svh"
module lugc_los_detect (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_clear,
  input wire logic i_bit_strobe,
  input wire logic i_bit_mark,
  input wire logic i_extended,
  output logic o_los
);
  typedef struct packed {
    logic [`LUGC_CNT_W-1:0] zeros;
    logic los;
  } lugc_los_s;
  lugc_los_s st;
  lugc_los_s next_st;
  logic [`LUGC_CNT_W-1:0] limit;
  always_comb begin
    next_st = st;
    limit = i_extended ? `LUGC_CNT_W'(`LUGC_LOS_LONG) : `LUGC_CNT_W'(`LUGC_LOS_SHORT);
    if (i_bit_strobe) begin
      if (i_bit_mark) begin
        next_st.zeros = '0;
        next_st.los = 1'b0;
      end else if (st.zeros < limit) begin
        next_st.zeros = st.zeros + `LUGC_CNT_W'(1);
      end
      // A mark clears the condition; the limit reached declares it. [R10]
      if (!i_bit_mark && (st.zeros + `LUGC_CNT_W'(1) >= limit)) begin
        next_st.los = 1'b1;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || i_clear) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_los = st.los;
endmodule

// ---- logic/lugc_global_ctrl.sv ----
/*
  Line unit global control register 0 with the framer-bypass rail path it steers.
  Assumes a simple synchronous byte register port and line clocks slower than the system clock.
*/
`include "lugc_regs.svh"
// Functional notes
// (R1) The rail-format bit picks dual rail when 0 and single rail when 1.
// (R2) With auto all-ones set, transmit sends all ones for as long as loss of signal lasts.
// (R3) Receive rails update on the rising receive clock edge when the edge bit is 0, else falling.
// (R4) Transmit rails are sampled on the falling transmit clock edge when the bit is 0, else rising.
// (R5) The polarity bit makes transmit input and receive output active low when set; in dual rail the receive negative rail stays 0 whatever the polarity bit.
// (R6) With global interrupt enable clear, the interrupt output never asserts; the registered output can stay high for one cycle after the bit clears.
// (R7) With it set, the interrupt is the AND of both enables and the source status.
// (R8) A soft reset bit held at 1 for over 10 us starts a device-wide reset.
// (R9) The soft reset clears the line rails, the interrupt and the loss-of-signal detector but keeps the register contents.
// (R10) Loss of signal is declared after 175 zeros, or 4096 with extended detection.
// (R11) Bit 2 reads as zero and writing it has no effect.
module lugc_global_ctrl (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_extended_los_enable,
  input wire logic [7:0] i_source_status,
  input wire logic [7:0] i_source_enable,
  input wire logic i_rx_line_clock,
  input wire logic i_rx_line_data,
  input wire logic i_tx_line_clock,
  input wire logic i_tx_positive_rail,
  input wire logic i_tx_negative_rail,
  input wire logic [1:0] i_framer_tx_rail,
  output logic o_rx_positive_rail,
  output logic o_rx_negative_rail,
  output logic [1:0] o_line_tx_rail,
  output logic o_rx_loss_of_signal,
  output logic o_rail_format_select,
  output logic o_irq,
  output logic o_device_reset
);
  typedef struct packed {
    logic [7:0] gcr0;
    lugc_pkg::lugc_srst_e srst_state;
    logic [`LUGC_CNT_W-1:0] srst_cnt;
    logic [1:0] rxclk_sync;
    logic [1:0] txclk_sync;
    logic [1:0] rxd_sync;
    lugc_pkg::lugc_rail_s txd_sync0;
    lugc_pkg::lugc_rail_s txd_sync1;
    logic rxclk_prev;
    logic txclk_prev;
    logic rx_pos;
    logic rx_neg;
    lugc_pkg::lugc_rail_s tx_line;
    logic irq;
    logic dev_reset;
  } lugc_state_s;
  lugc_state_s st;
  lugc_state_s next_st;
  logic los;
  lugc_pkg::lugc_rail_s tx_sample;
  logic rx_bit_strobe;

  function automatic logic edge_hit(input logic prev, input logic now, input logic falling);
    edge_hit = falling ? (prev && !now) : (!prev && now);
  endfunction

  assign rx_bit_strobe = edge_hit(st.rxclk_prev, st.rxclk_sync[1], 1'b0);

  // The soft reset clears the detector but never the register itself. [R9]
  lugc_los_detect u_los (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_clear(st.dev_reset),
    .i_bit_strobe(rx_bit_strobe),
    .i_bit_mark(st.rxd_sync[1]),
    .i_extended(i_extended_los_enable),
    .o_los(los)
  );

  always_comb begin
    next_st = st;
    tx_sample = st.txd_sync1;
    next_st.rxclk_sync = {st.rxclk_sync[0], i_rx_line_clock};
    next_st.txclk_sync = {st.txclk_sync[0], i_tx_line_clock};
    next_st.rxd_sync = {st.rxd_sync[0], i_rx_line_data};
    next_st.txd_sync0 = '{pos: i_tx_positive_rail, neg: i_tx_negative_rail};
    next_st.txd_sync1 = st.txd_sync0;
    next_st.rxclk_prev = st.rxclk_sync[1];
    next_st.txclk_prev = st.txclk_sync[1];
    if (i_reg_wr) begin
      next_st.gcr0 = i_reg_wdata & `LUGC_GCR0_WMASK; // [R11]
    end
    // Receive rails follow the selected receive clock edge. [R3]
    if (edge_hit(st.rxclk_prev, st.rxclk_sync[1], st.gcr0[`LUGC_BIT_RXEDGE])) begin
      // Single rail carries data on the positive rail only. [R1]
      next_st.rx_pos = st.rxd_sync[1] ^ st.gcr0[`LUGC_BIT_POL]; // [R5]
      next_st.rx_neg = st.gcr0[`LUGC_BIT_RAIL] ? st.gcr0[`LUGC_BIT_POL] : 1'b0;
    end
    // Transmit rails are taken on the selected transmit clock edge. [R4]
    if (edge_hit(st.txclk_prev, st.txclk_sync[1], !st.gcr0[`LUGC_BIT_TXEDGE])) begin
      tx_sample.pos = st.txd_sync1.pos ^ st.gcr0[`LUGC_BIT_POL]; // [R5]
      tx_sample.neg = st.txd_sync1.neg ^ st.gcr0[`LUGC_BIT_POL];
      next_st.tx_line = tx_sample;
      if (st.gcr0[`LUGC_BIT_RAIL]) begin
        next_st.tx_line.neg = 1'b0; // [R1]
      end
    end
    if (st.gcr0[`LUGC_BIT_ATAO] && los) begin
      next_st.tx_line = '{pos: 1'b1, neg: !st.gcr0[`LUGC_BIT_RAIL]}; // [R2]
    end
    // Masked by the global enable before any source can reach the pin. [R6] [R7]
    next_st.irq = st.gcr0[`LUGC_BIT_GIE] && |(i_source_status & i_source_enable);
    next_st.dev_reset = 1'b0;
    case (st.srst_state)
      lugc_pkg::LUGC_ST_IDLE: begin
        next_st.srst_cnt = '0;
        if (st.gcr0[`LUGC_BIT_SRST]) begin
          next_st.srst_state = lugc_pkg::LUGC_ST_HOLD;
        end
      end
      lugc_pkg::LUGC_ST_HOLD: begin
        // Only a bit held past the minimum time triggers the reset. [R8]
        if (!st.gcr0[`LUGC_BIT_SRST]) begin
          next_st.srst_state = lugc_pkg::LUGC_ST_IDLE;
        end else if (st.srst_cnt >= `LUGC_CNT_W'(`LUGC_SRST_CYCLES)) begin
          next_st.srst_state = lugc_pkg::LUGC_ST_RESET;
        end else begin
          next_st.srst_cnt = st.srst_cnt + `LUGC_CNT_W'(1);
        end
      end
      lugc_pkg::LUGC_ST_RESET: begin
        // Reset lasts while the bit stays set, and the register bits survive it. [R9]
        next_st.dev_reset = st.gcr0[`LUGC_BIT_SRST];
        if (!st.gcr0[`LUGC_BIT_SRST]) begin
          next_st.srst_state = lugc_pkg::LUGC_ST_IDLE;
        end
      end
      default: begin
        next_st.srst_state = lugc_pkg::LUGC_ST_IDLE;
      end
    endcase
    if (st.dev_reset) begin
      // Line-side state returns to idle; the register and sequencer are kept. [R9]
      next_st.rx_pos = 1'b0;
      next_st.rx_neg = 1'b0;
      next_st.tx_line = '0;
      next_st.irq = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st <= '0;
      st.gcr0 <= `LUGC_GCR0_RESET;
      st.srst_state <= lugc_pkg::LUGC_ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign o_reg_rdata = st.gcr0;
  assign o_rx_positive_rail = st.rx_pos;
  assign o_rx_negative_rail = st.rx_neg;
  assign o_line_tx_rail = {st.tx_line.pos, st.tx_line.neg};
  assign o_rx_loss_of_signal = los;
  assign o_rail_format_select = st.gcr0[`LUGC_BIT_RAIL];
  assign o_irq = st.irq;
  assign o_device_reset = st.dev_reset;
endmodule

// ---- sim/lugc_assertions.sv ----
/* Checker for the global control register, its interrupt gate and its soft reset.
   Assumes binding to lugc_global_ctrl, clocked at 100 MHz. */
module lugc_checker (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic [7:0] i_source_status,
  input wire logic [7:0] i_source_enable,
  input wire logic o_rail_format_select,
  input wire logic o_irq,
  input wire logic o_device_reset
);
  logic [10:0] hold_cnt;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // The hold time is far too long to unroll, so a saturating counter measures it.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !o_reg_rdata[0]) begin
      hold_cnt <= 11'h000;
    end else if (hold_cnt != 11'h7FF) begin
      hold_cnt <= hold_cnt + 11'h001;
    end
  end
  sequence s_bit0_low; !o_reg_rdata[0] [*3]; endsequence
  property p_wr; i_reg_wr |=> o_reg_rdata == ($past(i_reg_wdata) & 8'hFB); endproperty
  a_wr: assert property (p_wr) else $error("write value not held");
  property p_bit2; o_reg_rdata[2] == 1'b0; endproperty
  a_bit2: assert property (p_bit2) else $error("unused bit reads one");
  property p_rail; $stable(o_reg_rdata) [*2] |-> o_rail_format_select == o_reg_rdata[7]; endproperty
  a_rail: assert property (p_rail) else $error("rail select differs");
  property p_gie_off; !$past(o_reg_rdata[1]) |-> !o_irq; endproperty
  a_gie_off: assert property (p_gie_off) else $error("irq while gated");
  property p_irq; o_irq == $past(o_reg_rdata[1] && |(i_source_status & i_source_enable)); endproperty
  a_irq: assert property (p_irq) else $error("irq wrong");
  property p_srst_min; o_device_reset && o_reg_rdata[0] |-> hold_cnt >= 11'h3DE; endproperty
  a_srst_min: assert property (p_srst_min) else $error("reset too early");
  property p_srst_on; hold_cnt == 11'h3F2 |-> o_device_reset; endproperty
  a_srst_on: assert property (p_srst_on) else $error("reset missing");
  property p_srst_off; s_bit0_low |-> !o_device_reset; endproperty
  a_srst_off: assert property (p_srst_off) else $error("reset stuck");
  property p_keep; o_device_reset && !$past(i_reg_wr) |-> $stable(o_reg_rdata); endproperty
  a_keep: assert property (p_keep) else $error("register lost in reset");
endmodule
bind lugc_global_ctrl lugc_checker u_chk (.i_clk, .i_reset_n, .i_reg_wr, .i_reg_wdata,
  .o_reg_rdata, .i_source_status, .i_source_enable, .o_rail_format_select, .o_irq,
  .o_device_reset);

// ---- sim/lugc_bench.sv ----
/* Self-checking bench for the global control register block.
   Assumes the design files are compiled first; the line clock runs at 80 ns. */
module lugc_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic wr = 1'b0;
  logic lclk = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic rxd = 1'b0;
  logic txp = 1'b0;
  logic rxp, rxn;
  logic [7:0] sts = 8'h00;
  logic [7:0] ena = 8'h00;
  logic [7:0] rdata;
  logic [1:0] txr;
  logic los, rsel, irq, drst;
  int miscompares = 0;
  int checked = 0;
  always #5 i_clk = ~i_clk;
  lugc_global_ctrl DUT (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_wr(wr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_extended_los_enable(1'b0),
    .i_source_status(sts), .i_source_enable(ena), .i_rx_line_clock(lclk),
    .i_rx_line_data(rxd), .i_tx_line_clock(lclk), .i_tx_positive_rail(txp),
    .i_tx_negative_rail(1'b0), .i_framer_tx_rail(2'b00), .o_rx_positive_rail(rxp),
    .o_rx_negative_rail(rxn), .o_line_tx_rail(txr), .o_rx_loss_of_signal(los),
    .o_rail_format_select(rsel), .o_irq(irq), .o_device_reset(drst));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrg(input logic [7:0] d);
    @(posedge i_clk) wr <= 1'b1;
    wdata <= d;
    @(posedge i_clk) wr <= 1'b0;
    @(posedge i_clk) #1;
  endtask
  task automatic lbits(input int n);
    repeat (n) begin
      repeat (4) @(posedge i_clk) lclk <= 1'b1;
      repeat (4) @(posedge i_clk) lclk <= 1'b0;
    end
    #1;
  endtask
  task automatic t_regs();
    chk(rdata, 8'h00);
    wrg(8'hFF);
    chk(rdata, 8'hFB);
    wrg(8'h80);
    chk({7'h00, rsel}, 8'h01);
  endtask
  task automatic t_irq();
    sts <= 8'h04;
    ena <= 8'h04;
    wrg(8'h00);
    chk({7'h00, irq}, 8'h00);
    wrg(8'h02);
    chk({7'h00, irq}, 8'h01);
    @(posedge i_clk) ena <= 8'h00;
    repeat (2) @(posedge i_clk);
    chk({7'h00, irq}, 8'h00);
  endtask
  task automatic t_rails();
    wrg(8'h00);
    rxd <= 1'b1;
    txp <= 1'b1;
    lbits(2);
    chk({7'h00, rxp}, 8'h01);
    chk({7'h00, rxn}, 8'h00);
    chk({6'h00, txr}, 8'h02);
    wrg(8'h18);
    lbits(2);
    chk({7'h00, rxp}, 8'h00);
    chk({6'h00, txr}, 8'h01);
    rxd <= 1'b0;
    txp <= 1'b0;
  endtask
  task automatic t_los();
    wrg(8'h40);
    lbits(170);
    chk({7'h00, los}, 8'h00);
    lbits(10);
    chk({7'h00, los}, 8'h01);
    repeat (3) @(posedge i_clk) #1;
    chk({7'h00, txr[1]}, 8'h01);
  endtask
  task automatic t_srst();
    wrg(8'h01);
    repeat (1010) @(posedge i_clk);
    #1 chk({7'h00, drst}, 8'h01);
    chk(rdata, 8'h01);
    wrg(8'h00);
    repeat (3) @(posedge i_clk);
    #1 chk({7'h00, drst}, 8'h00);
  endtask
  task automatic finish_test();
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk) #1;
    t_regs();
    t_irq();
    t_rails();
    t_los();
    t_srst();
    finish_test();
  end
  // The tests need about 2500 cycles, so this limit only trips on a hang.
  initial begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    finish_test();
  end
endmodule
